// ### design/rfs_defines.svh
// Constants for the reset flag and sync select block.
// Assumes a 10 MHz system clock and a plain strobe register port.
`ifndef RFS_DEFINES_SVH
`define RFS_DEFINES_SVH

// Register offsets
`define RFS_ADDR_ENABLE   4'h0
`define RFS_ADDR_FLAG     4'h1
`define RFS_ADDR_ORIGIN   4'h2
`define RFS_ADDR_SYNCCFG  4'h3
`define RFS_ADDR_CRATE    4'h4
`define RFS_ADDR_IRQ_STAT 4'h5
`define RFS_ADDR_IRQ_MASK 4'h6
`define RFS_ADDR_SWRESET  4'h7

// Source bit positions in enable and request fields and in the processor origin
`define RFS_SRC_PROC_FAIL 0
`define RFS_SRC_PROC_SW   1
`define RFS_SRC_PROC_FP   2
`define RFS_SRC_BRD_SW    3
`define RFS_SRC_BRD_FP    4
`define RFS_SRC_BRD_WDOG  5

// Reset values: only the two front panel sources enabled
`define RFS_ENABLE_RST    6'h14
`define RFS_CRATE_RST     8'h00

// Interrupt status bit positions
`define RFS_IRQ_PROC      0
`define RFS_IRQ_BRD       1

// Sync clock timing
`define RFS_SYS_CLK_HZ    10000000
`define RFS_SYNC_CLK_HZ   1250000
`define RFS_SYNC_HALF     (`RFS_SYS_CLK_HZ / (2 * `RFS_SYNC_CLK_HZ))

`endif

// ### design/rfs_pkg.sv
// Types for the reset flag and sync select block.
// Assumes rfs_defines.svh is compiled alongside.
package rfs_pkg;

    // Register port request from software
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rfs_req_s;

    // Section reset outputs
    typedef struct packed {
        logic proc;
        logic brd;
    } rfs_sect_s;

endpackage : rfs_pkg

// ### design/rfs_reset_flag.sv
// Reset source enables, reset flag, last reset origin, sync clock select.
// Assumes synchronous inputs on sys_clk_i and a strobe register port.
//
// Summary of operation
// RULE_01: Flag sets on first enabled source request.
// RULE_02: Disabled sources never reset their section.
// RULE_03: Reset enables only both front panel sources.
// RULE_04: Flag LED follows the reset flag.
// RULE_05: Processor sources: failure, software, front panel.
// RULE_06: Board sources: software, front panel, watchdog.
// RULE_07: Last reset origin kept per section.
// RULE_08: Master makes 1.25 MHz clock, drives it, LED on.
// RULE_09: Slave takes sync clock as input, LED off.
// RULE_10: Configurable crate number register held.
// RULE_11: Flag sticky until reset or enable rewrite.
`include "rfs_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module rfs_reset_flag #(
    parameter int SYNC_HALF = `RFS_SYNC_HALF  // System cycles per sync half period
) (
    input  wire logic        sys_clk_i,         // 10 MHz system clock
    input  wire logic        reset_i,           // Power-up reset, async, high
    input  wire logic [3:0]  reg_addr_i,        // Register address
    input  wire logic [7:0]  reg_wdata_i,       // Write data
    input  wire logic        reg_wr_i,          // Write strobe
    input  wire logic        reg_rd_i,          // Read strobe
    output logic      [7:0]  reg_rdata_o,       // Read data, cycle after strobe
    input  wire logic        proc_fail_i,       // Processor failure request
    input  wire logic        proc_fp_i,         // Processor front panel request
    input  wire logic        brd_fp_i,          // Board front panel request
    input  wire logic        brd_wdog_i,        // Board watchdog request
    input  wire logic        sync_clk_i,        // Sync connector input level
    output logic             sync_clk_o,        // Sync connector output level
    output logic             sync_clk_oe_o,     // Sync connector output enable
    output logic             supply_unit_sync_clock_o, // Clock used for supplies
    output logic             master_led_o,      // Master LED
    output logic             reset_flag_o,      // Reset indicator output
    output logic             reset_flag_led_o,  // Reset indicator LED
    output logic             processor_section_reset_o, // Processor reset pulse
    output logic             board_section_reset_o,     // Board reset pulse
    output logic             irq_o              // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode

    rfs_pkg::rfs_req_s req;                     // Bundled software request
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    wire wr_enable  = req.wr && (req.addr == `RFS_ADDR_ENABLE);
    wire wr_crate   = req.wr && (req.addr == `RFS_ADDR_CRATE);
    wire wr_sync    = req.wr && (req.addr == `RFS_ADDR_SYNCCFG);
    wire wr_istat   = req.wr && (req.addr == `RFS_ADDR_IRQ_STAT);
    wire wr_imask   = req.wr && (req.addr == `RFS_ADDR_IRQ_MASK);
    wire wr_swreset = req.wr && (req.addr == `RFS_ADDR_SWRESET);

    ////////////////////////////////////////////////////////////////////////////
    // Source requests and enables

    logic [5:0] enable_q;                       // Per-source enable
    logic [7:0] crate_q;                        // Crate number in the chain
    logic       master_q;                       // 1: sync master, 0: slave
    logic [5:0] raw_req;                        // All six raw requests
    logic [5:0] act_req;                        // Enabled requests only

    // Software command sources are not implemented yet: the strobe register
    // pulses them so the path exists, but nothing else drives them.
    always_comb begin
        raw_req = 6'h00;
        raw_req[`RFS_SRC_PROC_FAIL] = proc_fail_i;                    // RULE_05
        raw_req[`RFS_SRC_PROC_SW]   = wr_swreset & reg_wdata_i[0];    // RULE_05
        raw_req[`RFS_SRC_PROC_FP]   = proc_fp_i;                      // RULE_05
        raw_req[`RFS_SRC_BRD_SW]    = wr_swreset & reg_wdata_i[1];    // RULE_06
        raw_req[`RFS_SRC_BRD_FP]    = brd_fp_i;                       // RULE_06
        raw_req[`RFS_SRC_BRD_WDOG]  = brd_wdog_i;                     // RULE_06
    end

    assign act_req = raw_req & enable_q;        // RULE_02

    wire [2:0] proc_act = act_req[2:0];         // Processor section sources
    wire [2:0] brd_act  = act_req[5:3];         // Board section sources
    wire       any_act  = |act_req;

    // Enables, crate number and sync mode
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            enable_q <= `RFS_ENABLE_RST;        // RULE_03
            crate_q  <= `RFS_CRATE_RST;
            master_q <= 1'b1;
        end else begin
            if (wr_enable) enable_q <= reg_wdata_i[5:0];
            if (wr_crate)  crate_q  <= reg_wdata_i;   // RULE_10
            if (wr_sync)   master_q <= reg_wdata_i[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset flag, section resets and origin capture

    logic       flag_q;                         // Sticky reset indicator
    logic [2:0] proc_origin_q;                  // Last processor reset source
    logic [2:0] brd_origin_q;                   // Last board reset source
    logic       proc_rst_q;                     // Processor section reset pulse
    logic       brd_rst_q;                      // Board section reset pulse
    logic       flag_led_q;                     // LED copy of the flag

    // A request in the same cycle as an enable rewrite wins, so no event lost.
    wire flag_d = any_act ? 1'b1 : (wr_enable ? 1'b0 : flag_q);       // RULE_01 RULE_11

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag_q        <= 1'b0;
            flag_led_q    <= 1'b0;
            proc_origin_q <= 3'h0;
            brd_origin_q  <= 3'h0;
            proc_rst_q    <= 1'b0;
            brd_rst_q     <= 1'b0;
        end else begin
            flag_q     <= flag_d;               // RULE_01 RULE_11
            flag_led_q <= flag_d;               // RULE_04
            proc_rst_q <= |proc_act;            // RULE_02
            brd_rst_q  <= |brd_act;             // RULE_02
            if (|proc_act) proc_origin_q <= proc_act;   // RULE_07
            if (|brd_act)  brd_origin_q  <= brd_act;    // RULE_07
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync clock: divider in master mode, connector input in slave mode

    localparam int CW = $clog2(SYNC_HALF + 1);
    logic [CW-1:0] div_q;                       // Half period counter
    logic          gen_q;                       // Internally generated clock
    logic          sync_out_q;                  // Registered connector drive
    logic          sync_oe_q;                   // Registered connector enable
    logic          sync_use_q;                  // Registered clock in use
    logic          led_q;                       // Registered master LED

    wire div_wrap = (div_q == CW'(SYNC_HALF - 1));

    // Divider free runs so the master clock keeps a steady duty cycle.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q <= '0;
            gen_q <= 1'b0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + CW'(1);
            if (div_wrap) gen_q <= ~gen_q;      // RULE_08
        end
    end

    // Slave never drives the connector, avoiding a fight with upstream.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_out_q <= 1'b0;
            sync_oe_q  <= 1'b0;
            sync_use_q <= 1'b0;
            led_q      <= 1'b0;
        end else begin
            sync_oe_q  <= master_q;             // RULE_08 RULE_09
            sync_out_q <= master_q & gen_q;     // RULE_08
            sync_use_q <= master_q ? gen_q : sync_clk_i;  // RULE_09
            led_q      <= master_q;             // RULE_08 RULE_09
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: section reset events, write one to clear

    logic [1:0] istat_q;                        // Sticky event bits
    logic [1:0] imask_q;                        // Interrupt enables
    logic       irq_q;                          // Registered interrupt
    wire  [1:0] ev = {|brd_act, |proc_act};
    wire  [1:0] istat_d = ev | (istat_q & ~({2{wr_istat}} & reg_wdata_i[1:0]));

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            istat_q <= 2'h0;
            imask_q <= 2'h0;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= istat_d;                 // Set wins over clear
            if (wr_imask) imask_q <= reg_wdata_i[1:0];
            irq_q   <= |(istat_d & (wr_imask ? reg_wdata_i[1:0] : imask_q));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data path
    // Read data are zero outside the cycle after a read strobe, so a
    // wired-or bus of several blocks needs no extra enable.
    // Reading has no side effect: status bits clear only by a write.

    logic [7:0] rsel;                           // Selected read word
    logic [7:0] rdata_q;                        // Read data register

    always_comb begin
        unique case (req.addr)
            `RFS_ADDR_ENABLE:   rsel = {2'h0, enable_q};
            `RFS_ADDR_FLAG:     rsel = {7'h00, flag_q};
            `RFS_ADDR_ORIGIN:   rsel = {1'b0, brd_origin_q, 1'b0, proc_origin_q};
            `RFS_ADDR_SYNCCFG:  rsel = {7'h00, master_q};
            `RFS_ADDR_CRATE:    rsel = crate_q;
            `RFS_ADDR_IRQ_STAT: rsel = {6'h00, istat_q};
            `RFS_ADDR_IRQ_MASK: rsel = {6'h00, imask_q};
            default:            rsel = 8'h00;   // Unmapped and write-only
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) rdata_q <= 8'h00;
        else         rdata_q <= req.rd ? rsel : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Every output comes straight from a flip-flop, so the pins never glitch
    // while the request inputs or the register port settle.
    // The cost is one cycle of latency on every indication.

    assign reg_rdata_o               = rdata_q;
    assign reset_flag_o              = flag_q;
    assign reset_flag_led_o          = flag_led_q;
    assign processor_section_reset_o = proc_rst_q;
    assign board_section_reset_o     = brd_rst_q;
    assign sync_clk_o                = sync_out_q;
    assign sync_clk_oe_o             = sync_oe_q;
    assign supply_unit_sync_clock_o  = sync_use_q;
    assign master_led_o              = led_q;
    assign irq_o                     = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // All checks run on the system clock and sleep during power-up reset.
    // Sequences stay a few cycles long: long waits are counted in helper
    // logic such as the divider rather than unrolled in a property, which
    // keeps the formal and simulation tools fast.

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    flag_sets_a: assert property (any_act |=> reset_flag_o) // RULE_01
        else $error("flag not set after enabled request");
    flag_sticky_a: assert property (reset_flag_o && !wr_enable |=> reset_flag_o) // RULE_11
        else $error("flag dropped without enable rewrite");
    disabled_quiet_a: assert property ( // RULE_02
        (proc_fp_i && !enable_q[`RFS_SRC_PROC_FP] && !proc_fail_i
         && !(enable_q[1] && wr_swreset)) |=> !processor_section_reset_o)
        else $error("disabled source reset processor section");
    led_follows_a: assert property (reset_flag_led_o == reset_flag_o) // RULE_04
        else $error("flag LED differs from flag");
    proc_origin_a: assert property (|proc_act |=> proc_origin_q == $past(proc_act)) // RULE_07
        else $error("processor origin not captured");
    wdog_origin_a: assert property ( // RULE_06
        brd_wdog_i && enable_q[`RFS_SRC_BRD_WDOG] |=> brd_origin_q[2] && board_section_reset_o)
        else $error("watchdog reset not seen");
    master_drive_a: assert property (master_q |=> sync_clk_oe_o && master_led_o) // RULE_08
        else $error("master not driving sync");
    slave_input_a: assert property ( // RULE_09
        !master_q |=> !sync_clk_oe_o && !master_led_o && supply_unit_sync_clock_o == $past(sync_clk_i))
        else $error("slave mode wrong");
    // The divider restarts from zero after each wrap
    gen_period_a: assert property (div_wrap |=> div_q == '0) // RULE_08
        else $error("sync divider did not restart");
    // Between wraps it counts up by one, so a half period is SYNC_HALF cycles
    div_step_a: assert property (!div_wrap |=> div_q == $past(div_q) + CW'(1)) // RULE_08
        else $error("sync divider skipped a count");
    // The generated clock moves on a wrap and only there
    gen_toggle_a: assert property (div_wrap |=> gen_q != $past(gen_q)) // RULE_08
        else $error("sync clock did not toggle");
    gen_hold_a: assert property (!div_wrap |=> gen_q == $past(gen_q)) // RULE_08
        else $error("sync clock moved between wraps");
    crate_hold_a: assert property (wr_crate |=> crate_q == $past(reg_wdata_i)) // RULE_10
        else $error("crate number not stored");

    ////////////////////////////////////////////////////////////////////////////
    // Further checks on sections, interrupts and the register port

    // An enabled processor request resets its section on the next edge
    proc_reset_a: assert property (|proc_act |=> processor_section_reset_o) // RULE_05
        else $error("processor section not reset");
    // An enabled board request resets its section on the next edge
    brd_reset_a: assert property (|brd_act |=> board_section_reset_o) // RULE_06
        else $error("board section not reset");
    // No enabled request at all means no section reset
    no_request_a: assert property ( // RULE_02
        !any_act |=> !processor_section_reset_o && !board_section_reset_o)
        else $error("section reset without enabled request");
    // The flag never rises without an enabled request
    flag_quiet_a: assert property (!reset_flag_o && !any_act |=> !reset_flag_o) // RULE_01
        else $error("flag set without request");
    // Board origin records exactly the sources active that cycle
    brd_origin_a: assert property (|brd_act |=> brd_origin_q == $past(brd_act)) // RULE_07
        else $error("board origin not captured");
    // Origins hold while no request arrives, so the display stays valid
    origin_hold_a: assert property ( // RULE_07
        !any_act |=> $stable(proc_origin_q) && $stable(brd_origin_q))
        else $error("origin changed without a request");
    // Rewriting the enables with no request pending clears the flag
    enable_clear_a: assert property (wr_enable && !any_act |=> !reset_flag_o) // RULE_11
        else $error("flag kept after enable rewrite");
    // Software command reaches the processor section only when enabled
    sw_proc_a: assert property ( // RULE_05
        wr_swreset && reg_wdata_i[0] && enable_q[`RFS_SRC_PROC_SW]
        |=> processor_section_reset_o && proc_origin_q[1])
        else $error("software processor reset lost");
    // Slave mode never drives the connector level either
    slave_quiet_a: assert property (!master_q |=> !sync_clk_o) // RULE_09
        else $error("slave drove the sync connector");
    // In master mode the connector carries the clock the supplies use
    master_copy_a: assert property ( // RULE_08
        master_q |=> sync_clk_o == supply_unit_sync_clock_o)
        else $error("connector differs from supply clock");
    // Mode register takes the written bit
    sync_mode_a: assert property (wr_sync |=> master_q == $past(reg_wdata_i[0]))
        else $error("sync mode not stored");
    // Interrupt output tracks the unmasked sticky status
    irq_level_a: assert property (irq_o == |(istat_q & imask_q))
        else $error("interrupt level wrong");
    // A section event always sets its status bit, even against a clear
    istat_set_a: assert property (|ev |=> (istat_q & $past(ev)) == $past(ev))
        else $error("status event lost");
    // Mask register takes the written bits
    mask_write_a: assert property (wr_imask |=> imask_q == $past(reg_wdata_i[1:0]))
        else $error("mask not stored");
    // Read data stand one cycle only, otherwise the port reads zero
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data held too long");
    // Crate number only changes on a write to it
    crate_keep_a: assert property (!wr_crate |=> $stable(crate_q)) // RULE_10
        else $error("crate number changed unasked");

    fp_reset_c:   cover property (proc_fp_i && enable_q[`RFS_SRC_PROC_FP]);
    wdog_c:       cover property (brd_wdog_i && enable_q[`RFS_SRC_BRD_WDOG]);
    slave_c:      cover property (!master_q ##1 !sync_clk_oe_o);
    irq_c:        cover property (irq_o);
    sw_reset_c:   cover property (wr_swreset && enable_q[`RFS_SRC_PROC_SW]);

endmodule : rfs_reset_flag

`default_nettype wire

// ### verification/rfs_crate_peer.sv
// Upstream crate model: drives the sync connector input of the block.
// Assumes the bench enables it only while the block is a slave.
`timescale 1ns/1ns
`default_nettype none

module rfs_crate_peer (
    input  wire logic sys_clk_i,   // Bench clock, used to pace the upstream clock
    input  wire logic drive_i,     // High while the upstream crate drives the line
    output logic      sync_clk_o   // Level seen on the sync connector
);
    logic [1:0] cnt_q;             // Paces a clock unlike the local divider

    ////////////////////////////////////////////////////////////////////////////
    // Upstream clock toggles every 3 cycles; when released the line changes
    // every cycle so a stale level can never pass for a real one
    always @(posedge sys_clk_i) begin
        cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
        if (!drive_i) begin
            sync_clk_o <= ~sync_clk_o;
        end else if (cnt_q == 2'h2) begin
            sync_clk_o <= ~sync_clk_o;
        end
    end

    initial begin
        cnt_q      = 2'h0;
        sync_clk_o = 1'b0;
    end
endmodule : rfs_crate_peer

`default_nettype wire

// ### verification/rfs_reset_flag_test.sv
// Self-checking bench for the reset flag and sync select block.
// Assumes the default divider of 4 and the register map in rfs_defines.svh.
`include "rfs_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module rfs_reset_flag_test;
    logic       clk = 1'b0;          // 10 MHz system clock
    logic       rst = 1'b1;          // Power-up reset
    logic [3:0] addr = 4'h0;         // Register address
    logic [7:0] wdata = 8'h00;       // Write data
    logic       wr = 1'b0;           // Write strobe
    logic       rd = 1'b0;           // Read strobe
    logic       rd_pend = 1'b0;      // Read data due this cycle
    logic [3:0] req = 4'h0;          // fail, proc fp, brd fp, watchdog
    logic       peer_on = 1'b0;      // Upstream crate drives the sync line
    logic       sync_in;             // Sync connector level from the peer
    logic [7:0] rdata;
    logic       s_o, s_oe, s_clk, m_led, flag, flag_led, p_rst, b_rst, irq;
    logic       a, s;
    logic [7:0] exp_q[$];            // Expected read data, oldest first
    string      name_q[$];
    int         mismatches = 0;
    int         n_tests = 0;
    int         k;

    rfs_reset_flag i_dut (.sys_clk_i(clk), .reset_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .proc_fail_i(req[0]), .proc_fp_i(req[1]), .brd_fp_i(req[2]),
        .brd_wdog_i(req[3]), .sync_clk_i(sync_in), .sync_clk_o(s_o),
        .sync_clk_oe_o(s_oe), .supply_unit_sync_clock_o(s_clk),
        .master_led_o(m_led), .reset_flag_o(flag), .reset_flag_led_o(flag_led),
        .processor_section_reset_o(p_rst), .board_section_reset_o(b_rst),
        .irq_o(irq));

    rfs_crate_peer i_peer (.sys_clk_i(clk), .drive_i(peer_on), .sync_clk_o(sync_in));

    initial begin
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison and closing
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    // Register port driver; a read notes its expected data in the queue
    task automatic reg_wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] ad, input logic [7:0] e, input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
    endtask : reg_rd

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_pend <= rd;
    always @(negedge clk) begin
        if (rd_pend && exp_q.size() > 0)
            check(name_q.pop_front(), rdata, exp_q.pop_front());
    end

    // Hold one request for a single cycle, look at its result
    task automatic pulse(input int i);
        @(posedge clk);
        req[i] <= 1'b1;
        @(posedge clk);
        req[i] <= 1'b0;
        @(negedge clk);
    endtask : pulse

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h15ad2f5d));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped address
        reg_rd(`RFS_ADDR_ENABLE, `RFS_ENABLE_RST, "enable");
        reg_rd(`RFS_ADDR_ENABLE, 8'h14, "enable_two_fp");
        reg_rd(`RFS_ADDR_SYNCCFG, 8'h01, "synccfg");
        reg_rd(`RFS_ADDR_FLAG, 8'h00, "flag_rst");
        reg_rd(4'h9, 8'h00, "unmapped");
        @(negedge clk);
        check("oe", {7'h0, s_oe}, 8'h01);
        check("master_led", {7'h0, m_led}, 8'h01);
        $display("test reset done");
        // Master divider: 4 transitions in 16 cycles
        k = 0;
        @(negedge clk) a = s_clk;
        repeat (16) begin
            @(negedge clk);
            if (s_clk !== a) k++;
            check("sync_out", {7'h0, s_o}, {7'h0, s_clk});
            a = s_clk;
        end
        check("sync_edges", k[7:0], 8'h04);
        $display("test master done");
        // Disabled sources do nothing
        pulse(0);
        check("proc_rst_off", {7'h0, p_rst}, 8'h00);
        reg_wr(`RFS_ADDR_SWRESET, 8'h03);
        @(negedge clk);
        check("sw_off", {6'h0, p_rst, b_rst}, 8'h00);
        check("flag_off", {7'h0, flag}, 8'h00);
        // Enabled board front panel request
        pulse(2);
        check("flag", {7'h0, flag}, 8'h01);
        check("flag_led", {7'h0, flag_led}, 8'h01);
        check("brd_rst", {6'h0, p_rst, b_rst}, 8'h01);
        repeat (3) @(negedge clk);
        check("flag_sticky", {7'h0, flag}, 8'h01);
        reg_rd(`RFS_ADDR_ORIGIN, 8'h20, "origin_brd_fp");
        reg_rd(`RFS_ADDR_IRQ_STAT, 8'h02, "irq_stat");
        $display("test request done");
        // Interrupt masking and clearing
        reg_wr(`RFS_ADDR_IRQ_MASK, 8'h00);
        @(negedge clk) a = irq;
        reg_wr(`RFS_ADDR_IRQ_MASK, 8'h03);
        @(negedge clk);
        check("irq_mask", {7'h0, a ^ irq}, 8'h01);
        reg_wr(`RFS_ADDR_IRQ_STAT, 8'h02);
        reg_rd(`RFS_ADDR_IRQ_STAT, 8'h00, "irq_clear");
        @(negedge clk);
        check("irq_low", {7'h0, irq}, 8'h00);
        $display("test irq done");
        // All sources enabled; rewrite of enables clears the flag
        reg_wr(`RFS_ADDR_ENABLE, 8'h3f);
        @(negedge clk);
        check("flag_clr", {7'h0, flag}, 8'h00);
        pulse(0);
        check("fail_rst", {6'h0, p_rst, b_rst}, 8'h02);
        reg_rd(`RFS_ADDR_ORIGIN, 8'h21, "origin_fail");
        pulse(1);
        check("pfp_rst", {6'h0, p_rst, b_rst}, 8'h02);
        reg_rd(`RFS_ADDR_ORIGIN, 8'h24, "origin_pfp");
        pulse(3);
        check("wdog_rst", {6'h0, p_rst, b_rst}, 8'h01);
        reg_rd(`RFS_ADDR_ORIGIN, 8'h44, "origin_wdog");
        reg_wr(`RFS_ADDR_SWRESET, 8'h03);
        repeat (2) @(negedge clk);
        reg_rd(`RFS_ADDR_ORIGIN, 8'h12, "origin_sw");
        reg_rd(`RFS_ADDR_FLAG, 8'h01, "flag_sw");
        $display("test sources done");
        // Crate number and ignored unmapped write
        k = $urandom;
        reg_wr(`RFS_ADDR_CRATE, k[7:0]);
        reg_rd(`RFS_ADDR_CRATE, k[7:0], "crate");
        reg_wr(4'hb, 8'($urandom));
        reg_rd(4'hb, 8'h00, "unmapped_wr");
        $display("test crate done");
        // Slave: connector is an input, clock follows upstream one cycle late
        reg_wr(`RFS_ADDR_SYNCCFG, 8'h00);
        peer_on <= 1'b1;
        repeat (2) @(negedge clk);
        check("slave_oe", {6'h0, s_oe, m_led}, 8'h00);
        @(negedge clk) s = sync_in;
        repeat (12) begin
            @(negedge clk);
            check("slave_clk", {7'h0, s_clk}, {7'h0, s});
            check("slave_out", {7'h0, s_o}, 8'h00);
            s = sync_in;
        end
        $display("test slave done");
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule : rfs_reset_flag_test

`default_nettype wire
